// [src/tcg_defs.vh]
`ifndef TCG_DEFS_VH
`define TCG_DEFS_VH

// ==========================================================
// Register addresses
`define TCG_ADDR_CH2_MODE 12'hf90
`define TCG_ADDR_CH1_MODE 12'hfa8
`define TCG_ADDR_TIMER_CTRL 12'hf92
`define TCG_ADDR_CH2_MODULO 12'hf94
`define TCG_ADDR_CARRIER_HW_MODULO 12'hf96
`define TCG_ADDR_LOW_COUNT 12'hf98
`define TCG_ADDR_CH1_MODULO 12'hfaa
`define TCG_ADDR_HIGH_COUNT 12'hfac
`define TCG_ADDR_CH1_OE 12'hfa6

// ==========================================================
// Reset values
`define TCG_MODE_RESET 8'h00
`define TCG_CTRL_RESET 4'h0
`define TCG_MODULO_RESET 8'hff

// ==========================================================
// Mode register fields
`define TCG_MODE_START_BIT 3
`define TCG_MODE_ENABLE_BIT 2
`define TCG_MODE_CLK_HI 6
`define TCG_MODE_CLK_LO 4
`define TCG_MODE_SEL_HI 1
`define TCG_MODE_SEL_LO 0
`define TCG_MODE_WRITE_MASK 8'h7f

// Mode select codes
`define TCG_SEL_CASCADE 2'b10
`define TCG_SEL_CARRIER 2'b11
`define TCG_SEL_IDLE 2'b00

// Clock select codes
`define TCG_CLK_C2 3'b010
`define TCG_CLK_C3 3'b011
`define TCG_CLK_C4 3'b100
`define TCG_CLK_C5 3'b101
`define TCG_CLK_C6 3'b110
`define TCG_CLK_C7 3'b111

// ==========================================================
// Timer control register fields
`define TCG_CTRL_ENV_BIT 0
`define TCG_CTRL_NEXT_ENV_BIT 1
`define TCG_CTRL_STYLE_BIT 2
`define TCG_CTRL_CH2_OE_BIT 3

// Prescaler width covers the slowest tap
`define TCG_PRESCALE_WIDTH 12

`endif

// [src/tcg_channel.v]
`timescale 1ns/1ps
`include "tcg_defs.vh"

module tcg_channel #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Control
	input wire tick_in,
	input wire clear_in,
	input wire wrap_in,
	input wire [WIDTH-1:0] modulo_in,
	// Status
	output reg [WIDTH-1:0] count_out,
	output wire hit_out,
	output wire carry_out
);

	// ==========================================================
	// Compare and carry
	assign hit_out = tick_in & (count_out == modulo_in);
	assign carry_out = tick_in & (&count_out);

	// ==========================================================
	// Counter
	always @(posedge clk_in) begin
		if (rst_in) begin
			count_out <= {WIDTH{1'b0}};
		end else if (clear_in) begin
			count_out <= {WIDTH{1'b0}};
		end else if (tick_in) begin
			// Wrap on the compare pulse so an interval spans modulo plus one ticks
			if (hit_out && wrap_in) begin
				count_out <= {WIDTH{1'b0}};
			end else begin
				count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // tcg_channel

// [src/tcg_timer.v]
`timescale 1ns/1ps
`include "tcg_defs.vh"

module tcg_timer (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// CPU data-memory access, byte and single-bit
	input wire [11:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_bit_wr_in,
	input wire [2:0] reg_bit_sel_in,
	input wire reg_bit_val_in,
	output reg [7:0] reg_rdata_out,
	// Request flags towards the interrupt controller
	input wire channel1_irq_clr_in,
	input wire channel2_irq_clr_in,
	output reg channel1_irq_flag_out,
	output reg channel2_irq_flag_out,
	// Output pins
	output reg carrier_output_pin_out,
	output reg channel1_output_pin_out
);

	// ==========================================================
	// Registers
	reg [7:0] channel1_mode_reg;
	reg [7:0] channel2_mode_reg;
	reg [7:0] channel1_modulo;
	reg [7:0] channel2_modulo;
	reg [7:0] carrier_high_width_modulo;
	reg [3:0] timer_control_reg;
	reg channel1_output_enable;
	reg [`TCG_PRESCALE_WIDTH-1:0] prescale;
	reg carrier_clock;
	reg timer_output_toggle;
	reg channel1_toggle;
	reg envelope_gate;

	wire [7:0] high_counter;
	wire [7:0] low_counter;
	wire low_hit;
	wire low_carry;
	wire high_hit;
	wire wr_ch2_mode = reg_wr_in && (reg_addr_in == `TCG_ADDR_CH2_MODE);
	wire wr_ch1_mode = reg_wr_in && (reg_addr_in == `TCG_ADDR_CH1_MODE);
	wire bit_ch2_mode = reg_bit_wr_in && (reg_addr_in == `TCG_ADDR_CH2_MODE);
	wire bit_ch1_mode = reg_bit_wr_in && (reg_addr_in == `TCG_ADDR_CH1_MODE);
	wire start_bit_sel = (reg_bit_sel_in == `TCG_MODE_START_BIT);

	// ==========================================================
	// Mode decode
	wire [1:0] ch1_sel = channel1_mode_reg[`TCG_MODE_SEL_HI:`TCG_MODE_SEL_LO];
	wire [1:0] ch2_sel = channel2_mode_reg[`TCG_MODE_SEL_HI:`TCG_MODE_SEL_LO];
	wire mode16 = (ch1_sel == `TCG_SEL_CASCADE) && (ch2_sel == `TCG_SEL_CASCADE);
	wire carrier_generator_mode = (ch2_sel == `TCG_SEL_CARRIER) &&
		(ch1_sel == `TCG_SEL_IDLE);
	wire start1 = channel1_mode_reg[`TCG_MODE_START_BIT];
	wire start2 = channel2_mode_reg[`TCG_MODE_START_BIT];
	wire run1 = channel1_mode_reg[`TCG_MODE_ENABLE_BIT];
	wire run2 = channel2_mode_reg[`TCG_MODE_ENABLE_BIT];
	wire output_style_flag = timer_control_reg[`TCG_CTRL_STYLE_BIT];
	wire next_envelope_bit = timer_control_reg[`TCG_CTRL_NEXT_ENV_BIT];
	wire envelope_bit = timer_control_reg[`TCG_CTRL_ENV_BIT];
	wire channel2_output_enable = timer_control_reg[`TCG_CTRL_CH2_OE_BIT];

	// ==========================================================
	// Prescaler taps of the main oscillator clock
	always @(posedge clk_in) begin
		if (rst_in) begin
			prescale <= {`TCG_PRESCALE_WIDTH{1'b0}};
		end else begin
			prescale <= prescale + {{(`TCG_PRESCALE_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// A divide by 2^k tap pulses when the low k prescaler bits are all ones
	reg ch2_pulse;
	always @* begin
		case (channel2_mode_reg[`TCG_MODE_CLK_HI:`TCG_MODE_CLK_LO])
			`TCG_CLK_C2: ch2_pulse = prescale[0];
			`TCG_CLK_C3: ch2_pulse = 1'b1;
			`TCG_CLK_C4: ch2_pulse = &prescale[9:0];
			`TCG_CLK_C5: ch2_pulse = &prescale[7:0];
			`TCG_CLK_C6: ch2_pulse = &prescale[5:0];
			`TCG_CLK_C7: ch2_pulse = &prescale[3:0];
			default: ch2_pulse = 1'b0;
		endcase
	end

	// Carrier rising edge: the low-width compare ends the low level
	wire carrier_rise = carrier_generator_mode && low_hit && !carrier_clock;

	reg ch1_pulse;
	always @* begin
		case (channel1_mode_reg[`TCG_MODE_CLK_HI:`TCG_MODE_CLK_LO])
			`TCG_CLK_C2: ch1_pulse = carrier_rise;
			`TCG_CLK_C3: ch1_pulse = &prescale[4:0];
			`TCG_CLK_C4: ch1_pulse = &prescale[11:0];
			`TCG_CLK_C5: ch1_pulse = &prescale[9:0];
			`TCG_CLK_C6: ch1_pulse = &prescale[7:0];
			`TCG_CLK_C7: ch1_pulse = &prescale[5:0];
			default: ch1_pulse = 1'b0;
		endcase
	end

	// ==========================================================
	// Counters
	wire low_tick = (mode16 || carrier_generator_mode) && run2 && ch2_pulse;
	wire full_match = mode16 && low_hit && (high_counter == channel1_modulo);
	// High counter follows low overflow in cascade mode, its own pulse in carrier mode, no tick in any other mode
	wire high_tick = mode16 ? low_carry : (carrier_generator_mode && run1 && ch1_pulse);
	wire [7:0] low_modulo = (carrier_generator_mode && carrier_clock) ?
		carrier_high_width_modulo : channel2_modulo;
	wire low_clear = start2 || full_match;
	wire high_clear = start1 || (mode16 && (start2 || full_match));

	tcg_channel #(
		.WIDTH(8)
	) u_low (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.tick_in(low_tick),
		.clear_in(low_clear),
		.wrap_in(carrier_generator_mode),
		.modulo_in(low_modulo),
		.count_out(low_counter),
		.hit_out(low_hit),
		.carry_out(low_carry)
	);

	tcg_channel #(
		.WIDTH(8)
	) u_high (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.tick_in(high_tick),
		.clear_in(high_clear),
		.wrap_in(carrier_generator_mode),
		.modulo_in(channel1_modulo),
		.count_out(high_counter),
		.hit_out(high_hit),
		.carry_out()
	);

	wire ch1_event = carrier_generator_mode && high_hit;
	wire ch2_carrier_event = carrier_generator_mode && low_hit && !carrier_clock;

	// ==========================================================
	// Mode and modulo registers
	always @(posedge clk_in) begin
		if (rst_in) begin
			channel1_mode_reg <= `TCG_MODE_RESET;
			channel2_mode_reg <= `TCG_MODE_RESET;
			channel1_modulo <= `TCG_MODULO_RESET;
			channel2_modulo <= `TCG_MODULO_RESET;
			carrier_high_width_modulo <= `TCG_MODULO_RESET;
			channel1_output_enable <= 1'b0;
		end else begin
			// Start bit lives one cycle, the cycle in which it acts
			channel1_mode_reg[`TCG_MODE_START_BIT] <= 1'b0;
			channel2_mode_reg[`TCG_MODE_START_BIT] <= 1'b0;
			if (wr_ch1_mode) begin
				channel1_mode_reg <= reg_wdata_in & `TCG_MODE_WRITE_MASK;
			end
			if (wr_ch2_mode) begin
				channel2_mode_reg <= reg_wdata_in & `TCG_MODE_WRITE_MASK;
			end
			if (bit_ch1_mode && start_bit_sel) begin
				channel1_mode_reg[`TCG_MODE_START_BIT] <= reg_bit_val_in;
			end
			if (bit_ch2_mode && start_bit_sel) begin
				channel2_mode_reg[`TCG_MODE_START_BIT] <= reg_bit_val_in;
			end
			if (reg_wr_in && (reg_addr_in == `TCG_ADDR_CH1_MODULO)) begin
				channel1_modulo <= reg_wdata_in;
			end
			if (reg_wr_in && (reg_addr_in == `TCG_ADDR_CH2_MODULO)) begin
				channel2_modulo <= reg_wdata_in;
			end
			if (reg_wr_in && (reg_addr_in == `TCG_ADDR_CARRIER_HW_MODULO)) begin
				carrier_high_width_modulo <= reg_wdata_in;
			end
			// Output enable ignores byte writes
			if (reg_bit_wr_in && (reg_addr_in == `TCG_ADDR_CH1_OE) &&
				(reg_bit_sel_in == 3'h0)) begin
				channel1_output_enable <= reg_bit_val_in;
			end
		end
	end

	// ==========================================================
	// Timer control register; the envelope reload outranks a CPU write
	always @(posedge clk_in) begin
		if (rst_in) begin
			timer_control_reg <= `TCG_CTRL_RESET;
		end else begin
			if (reg_wr_in && (reg_addr_in == `TCG_ADDR_TIMER_CTRL)) begin
				timer_control_reg <= reg_wdata_in[3:0];
			end else if (reg_bit_wr_in && (reg_addr_in == `TCG_ADDR_TIMER_CTRL) &&
				!reg_bit_sel_in[2]) begin
				timer_control_reg[reg_bit_sel_in[1:0]] <= reg_bit_val_in;
			end
			if (ch1_event) begin
				timer_control_reg[`TCG_CTRL_ENV_BIT] <= next_envelope_bit;
			end
		end
	end

	// ==========================================================
	// Waveform state
	always @(posedge clk_in) begin
		if (rst_in) begin
			carrier_clock <= 1'b0;
			timer_output_toggle <= 1'b0;
			channel1_toggle <= 1'b0;
			envelope_gate <= 1'b0;
		end else begin
			if (carrier_generator_mode && start2) begin
				carrier_clock <= 1'b1;
			end else if (carrier_generator_mode && low_hit) begin
				carrier_clock <= !carrier_clock;
			end
			if (full_match) begin
				timer_output_toggle <= !timer_output_toggle;
			end
			if (ch1_event) begin
				channel1_toggle <= !channel1_toggle;
			end
			// Gate only moves while carrier is low, so pulses keep full width
			if (!carrier_clock) begin
				envelope_gate <= envelope_bit;
			end
		end
	end

	// ==========================================================
	// Request flags; a set in the clearing cycle wins
	wire set_irq1 = ch1_event;
	wire set_irq2 = full_match || ch2_carrier_event;
	always @(posedge clk_in) begin
		if (rst_in) begin
			channel1_irq_flag_out <= 1'b0;
			channel2_irq_flag_out <= 1'b0;
		end else begin
			channel1_irq_flag_out <= set_irq1 ||
				(channel1_irq_flag_out && !channel1_irq_clr_in && !start1);
			channel2_irq_flag_out <= set_irq2 ||
				(channel2_irq_flag_out && !channel2_irq_clr_in && !start2);
		end
	end

	// ==========================================================
	// Pins, registered; disabled outputs sit low
	reg next_carrier_pin;
	always @* begin
		next_carrier_pin = 1'b0;
		if (carrier_generator_mode) begin
			// Gate low forces low; style selects carrier or steady high
			next_carrier_pin = envelope_gate && (output_style_flag || carrier_clock);
		end else if (mode16) begin
			next_carrier_pin = timer_output_toggle;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			carrier_output_pin_out <= 1'b0;
			channel1_output_pin_out <= 1'b0;
		end else begin
			carrier_output_pin_out <= channel2_output_enable && next_carrier_pin;
			channel1_output_pin_out <= channel1_output_enable && channel1_toggle;
		end
	end

	// ==========================================================
	// Read port, one cycle behind the address
	always @(posedge clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			case (reg_addr_in)
				`TCG_ADDR_CH1_MODE: reg_rdata_out <= channel1_mode_reg;
				`TCG_ADDR_CH2_MODE: reg_rdata_out <= channel2_mode_reg;
				`TCG_ADDR_TIMER_CTRL: reg_rdata_out <= {4'h0, timer_control_reg};
				`TCG_ADDR_CH1_MODULO: reg_rdata_out <= channel1_modulo;
				`TCG_ADDR_CH2_MODULO: reg_rdata_out <= channel2_modulo;
				`TCG_ADDR_CARRIER_HW_MODULO: reg_rdata_out <= carrier_high_width_modulo;
				`TCG_ADDR_HIGH_COUNT: reg_rdata_out <= high_counter;
				`TCG_ADDR_LOW_COUNT: reg_rdata_out <= low_counter;
				`TCG_ADDR_CH1_OE: reg_rdata_out <= {7'h00, channel1_output_enable};
				default: reg_rdata_out <= 8'h00;
			endcase
		end
	end

endmodule // tcg_timer

// [test/tcg_ir_rx.sv]
`timescale 1ns/1ps

// ==========================================================
// Receiver side: measures level runs on the carrier pin
module tcg_ir_rx (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Pin from the transmitter
	input wire pin_in,
	// Last completed runs, in clock cycles, and a count of edges seen
	output reg [15:0] high_width_out,
	output reg [15:0] low_width_out,
	output reg [15:0] edge_cnt_out
);
	reg [15:0] run;
	reg last;

	always @(posedge clk_in) begin
		if (rst_in) begin
			run <= 16'h0001;
			last <= 1'b0;
			high_width_out <= 16'h0000;
			low_width_out <= 16'h0000;
			edge_cnt_out <= 16'h0000;
		end else if (pin_in !== last) begin
			// A clipped high pulse shows up here as a short width
			if (last) begin
				high_width_out <= run;
			end else begin
				low_width_out <= run;
			end
			run <= 16'h0001;
			last <= pin_in;
			edge_cnt_out <= edge_cnt_out + 16'h0001;
		end else begin
			run <= run + 16'h0001;
		end
	end
endmodule // tcg_ir_rx

// [test/tcg_timer_asserts.sv]
`timescale 1ns/1ps
`include "tcg_defs.vh"

// ==========================================================
// Port-level checks of the timer block
module tcg_timer_asserts (
	// Clock and reset
	input wire clk_in,
	input wire rst_in,
	// Register port
	input wire [11:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_bit_wr_in,
	input wire [2:0] reg_bit_sel_in,
	input wire reg_bit_val_in,
	input wire [7:0] reg_rdata_out,
	// Flags and pins
	input wire channel1_irq_clr_in,
	input wire channel2_irq_clr_in,
	input wire channel1_irq_flag_out,
	input wire channel2_irq_flag_out,
	input wire carrier_output_pin_out,
	input wire channel1_output_pin_out
);
	wire mode_a = reg_addr_in == `TCG_ADDR_CH1_MODE || reg_addr_in == `TCG_ADDR_CH2_MODE;
	wire mod_a = reg_addr_in == `TCG_ADDR_CH2_MODULO || reg_addr_in == `TCG_ADDR_CH1_MODULO
		|| reg_addr_in == `TCG_ADDR_CARRIER_HW_MODULO;
	wire start = mode_a && ((reg_wr_in && reg_wdata_in[3])
		|| (reg_bit_wr_in && reg_bit_sel_in == 3'h3 && reg_bit_val_in));
	// Only the CPU changes these bits, so a shadow copy is exact
	reg oe1;
	reg oe2;
	reg [1:0] sel1;
	reg [1:0] sel2;

	always @(posedge clk_in) begin
		if (rst_in) begin
			oe1 <= 1'b0;
			oe2 <= 1'b0;
			sel1 <= 2'h0;
			sel2 <= 2'h0;
		end else begin
			if (reg_wr_in && reg_addr_in == `TCG_ADDR_TIMER_CTRL) begin
				oe2 <= reg_wdata_in[3];
			end else if (reg_bit_wr_in && reg_addr_in == `TCG_ADDR_TIMER_CTRL
				&& reg_bit_sel_in == 3'h3) begin
				oe2 <= reg_bit_val_in;
			end
			if (reg_bit_wr_in && reg_addr_in == `TCG_ADDR_CH1_OE && reg_bit_sel_in == 3'h0) begin
				oe1 <= reg_bit_val_in;
			end
			if (reg_wr_in && reg_addr_in == `TCG_ADDR_CH1_MODE) begin
				sel1 <= reg_wdata_in[1:0];
			end
			if (reg_wr_in && reg_addr_in == `TCG_ADDR_CH2_MODE) begin
				sel2 <= reg_wdata_in[1:0];
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	AST_RST_OUTS: assert property (disable iff (1'b0) rst_in |=>
		!(channel1_irq_flag_out || channel2_irq_flag_out || carrier_output_pin_out
		|| channel1_output_pin_out || (|reg_rdata_out)))
		else $error("Outputs not cleared by reset");
	AST_MODE_RD: assert property (reg_wr_in && mode_a ##1
		($stable(reg_addr_in) && !reg_wr_in && !reg_bit_wr_in)[*2]
		|=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'h77))
		else $error("Mode register readback wrong");
	AST_MODULO_RD: assert property (reg_wr_in && mod_a ##1
		($stable(reg_addr_in) && !reg_wr_in && !reg_bit_wr_in)[*2]
		|=> reg_rdata_out == $past(reg_wdata_in, 3))
		else $error("Modulo register readback wrong");
	AST_UNMAP: assert property (!mode_a && !mod_a && !(reg_addr_in inside
		{`TCG_ADDR_TIMER_CTRL, `TCG_ADDR_LOW_COUNT, `TCG_ADDR_HIGH_COUNT, `TCG_ADDR_CH1_OE})
		|=> reg_rdata_out == 8'h00)
		else $error("Unmapped address read not zero");
	AST_CTRL_NIBBLE: assert property (reg_addr_in == `TCG_ADDR_TIMER_CTRL |=>
		reg_rdata_out[7:4] == 4'h0)
		else $error("Control upper bits not zero");
	AST_FLAG1_HOLD: assert property (channel1_irq_flag_out && !channel1_irq_clr_in
		&& !start && !$past(start) |=> channel1_irq_flag_out)
		else $error("Channel 1 request dropped on its own");
	AST_FLAG2_HOLD: assert property (channel2_irq_flag_out && !channel2_irq_clr_in
		&& !start && !$past(start) |=> channel2_irq_flag_out)
		else $error("Channel 2 request dropped on its own");
	AST_OE2_LOW: assert property (!oe2 [*3] |-> !carrier_output_pin_out)
		else $error("Carrier pin high while disabled");
	AST_OE1_LOW: assert property (!oe1 [*3] |-> !channel1_output_pin_out)
		else $error("Channel 1 pin high while disabled");
	AST_CASC_TOGGLE: assert property ($rose(channel2_irq_flag_out) && oe2
		&& sel1 == 2'b10 && sel2 == 2'b10
		|-> ##[1:2] carrier_output_pin_out != $past(carrier_output_pin_out))
		else $error("Cascade request without pin toggle");
	AST_CH1_TOGGLE: assert property ($rose(channel1_irq_flag_out) && oe1
		&& sel1 == 2'b00 && sel2 == 2'b11
		|-> ##[1:2] channel1_output_pin_out != $past(channel1_output_pin_out))
		else $error("Channel 1 request without pin toggle");
endmodule // tcg_timer_asserts

bind tcg_timer tcg_timer_asserts i_tcg_timer_asserts (
	.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_bit_wr_in(reg_bit_wr_in),
	.reg_bit_sel_in(reg_bit_sel_in), .reg_bit_val_in(reg_bit_val_in),
	.reg_rdata_out(reg_rdata_out), .channel1_irq_clr_in(channel1_irq_clr_in),
	.channel2_irq_clr_in(channel2_irq_clr_in), .channel1_irq_flag_out(channel1_irq_flag_out),
	.channel2_irq_flag_out(channel2_irq_flag_out),
	.carrier_output_pin_out(carrier_output_pin_out),
	.channel1_output_pin_out(channel1_output_pin_out)
);

// [test/test_tcg_timer.sv]
`timescale 1ns/1ps
`include "tcg_defs.vh"

module test_tcg_timer;
	localparam [11:0] a_m1 = `TCG_ADDR_CH1_MODE;
	localparam [11:0] a_m2 = `TCG_ADDR_CH2_MODE;
	localparam [11:0] a_ctl = `TCG_ADDR_TIMER_CTRL;
	localparam [11:0] a_mod2 = `TCG_ADDR_CH2_MODULO;
	localparam [11:0] a_low = `TCG_ADDR_LOW_COUNT;
	reg clk_in;
	reg rst_in;
	reg [11:0] addr;
	reg [7:0] wdata;
	reg wr_stb;
	reg bit_stb;
	reg [2:0] bit_sel;
	reg bit_val;
	reg clr1;
	reg clr2;
	wire [7:0] rdata;
	wire flag1;
	wire flag2;
	wire pin2;
	wire pin1;
	wire [15:0] high_w;
	wire [15:0] low_w;
	wire [15:0] edges;
	integer error_cnt;
	integer tests_run;
	reg [15:0] snap;

	tcg_timer i_tcg_timer (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr_stb), .reg_bit_wr_in(bit_stb),
		.reg_bit_sel_in(bit_sel), .reg_bit_val_in(bit_val), .reg_rdata_out(rdata),
		.channel1_irq_clr_in(clr1), .channel2_irq_clr_in(clr2),
		.channel1_irq_flag_out(flag1), .channel2_irq_flag_out(flag2),
		.carrier_output_pin_out(pin2), .channel1_output_pin_out(pin1));
	tcg_ir_rx i_tcg_ir_rx (.clk_in(clk_in), .rst_in(rst_in), .pin_in(pin2),
		.high_width_out(high_w), .low_width_out(low_w), .edge_cnt_out(edges));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// ==========================================================
	// Bus tasks, all entered just after a falling edge
	task conclude;
		begin
			if (error_cnt == 0 && tests_run > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [11:0] a, input [7:0] d);
		begin
			addr = a;
			wdata = d;
			wr_stb = 1'b1;
			@(negedge clk_in);
			wr_stb = 1'b0;
		end
	endtask
	task bw(input [11:0] a, input [2:0] s, input v);
		begin
			addr = a;
			bit_sel = s;
			bit_val = v;
			bit_stb = 1'b1;
			@(negedge clk_in);
			bit_stb = 1'b0;
		end
	endtask
	// Two edges so a write just before is already visible
	task rd(input [11:0] a, input [7:0] exp);
		begin
			addr = a;
			repeat (2) @(negedge clk_in);
			chk(rdata, exp);
		end
	endtask
	task clr(input integer ch);
		begin
			clr1 = (ch == 1);
			clr2 = (ch == 2);
			@(negedge clk_in);
			clr1 = 1'b0;
			clr2 = 1'b0;
		end
	endtask
	task wait_hi(input integer s, input integer n);
		integer k;
		begin
			k = 0;
			while ((s == 1 ? flag1 : flag2) !== 1'b1 && k < n) begin
				@(negedge clk_in);
				k = k + 1;
			end
			if (k >= n) begin
				chk(16'h0000, 16'h0001);
				conclude;
			end
		end
	endtask
	task do_reset;
		begin
			rst_in = 1'b1;
			repeat (12) @(negedge clk_in);
			rst_in = 1'b0;
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{addr, wdata, wr_stb, bit_stb, bit_sel, bit_val, clr1, clr2} = 0;
		error_cnt = 0;
		tests_run = 0;
		do_reset;
		rd(a_m2, 8'h00);
		rd(a_m1, 8'h00);
		rd(a_ctl, 8'h00);
		rd(`TCG_ADDR_CH1_OE, 8'h00);
		wr(`TCG_ADDR_CH1_OE, 8'h01);
		rd(`TCG_ADDR_CH1_OE, 8'h00);
		bw(`TCG_ADDR_CH1_OE, 3'h0, 1'b1);
		rd(`TCG_ADDR_CH1_OE, 8'h01);
		rd(12'hf9e, 8'h00);
		// Cascade: high 01, low 02 gives 259 fx pulses per interval
		wr(`TCG_ADDR_CH1_MODULO, 8'h01);
		wr(a_mod2, 8'h02);
		rd(a_mod2, 8'h02);
		wr(a_m1, 8'h22);
		wr(a_ctl, 8'h08);
		wr(a_m2, 8'h3e);
		rd(a_m2, 8'h36);
		repeat (3) begin
			wait_hi(2, 300);
			clr(2);
		end
		repeat (4) @(negedge clk_in);
		chk(high_w, 16'd259);
		chk(low_w, 16'd259);
		wait_hi(2, 300);
		wr(a_m2, 8'h32);
		addr = a_low;
		repeat (2) @(negedge clk_in);
		snap = rdata;
		repeat (20) @(negedge clk_in);
		chk(rdata, snap);
		bw(a_m2, 3'h3, 1'b1);
		repeat (2) @(negedge clk_in);
		chk(flag2, 1'b0);
		rd(a_low, 8'h00);
		rd(a_m2, 8'h32);
		// Cascade on other taps: high 00, low 02 gives 3 pulses per interval
		wr(`TCG_ADDR_CH1_MODULO, 8'h00);
		wr(a_m2, 8'h7e);
		repeat (200) @(negedge clk_in);
		chk(high_w, 16'd48);
		chk(low_w, 16'd48);
		wr(a_m2, 8'h2e);
		repeat (40) @(negedge clk_in);
		chk(high_w, 16'd6);
		chk(low_w, 16'd6);
		// Carrier: 3 cycles high, 5 low; envelope every 4 carrier periods
		wr(`TCG_ADDR_CARRIER_HW_MODULO, 8'h02);
		wr(a_mod2, 8'h04);
		wr(a_ctl, 8'h0b);
		wr(a_m2, 8'h3f);
		wr(`TCG_ADDR_CH1_MODULO, 8'h03);
		wr(a_m1, 8'h2c);
		repeat (40) @(negedge clk_in);
		chk(high_w, 16'd3);
		chk(low_w, 16'd5);
		clr(1);
		wait_hi(1, 100);
		repeat (2) @(negedge clk_in);
		snap = pin1;
		clr(1);
		wait_hi(1, 100);
		repeat (2) @(negedge clk_in);
		chk(pin1, !snap[0]);
		wr(a_ctl, 8'h0f);
		repeat (20) @(negedge clk_in);
		snap = edges;
		repeat (40) @(negedge clk_in);
		chk(edges, snap);
		chk(pin2, 1'b1);
		wr(a_ctl, 8'h09);
		clr(1);
		wait_hi(1, 100);
		repeat (16) @(negedge clk_in);
		snap = edges;
		repeat (40) @(negedge clk_in);
		chk(edges, snap);
		chk(pin2, 1'b0);
		chk(high_w, 16'd3);
		wr(a_ctl, 8'h0b);
		repeat (80) @(negedge clk_in);
		chk(edges > snap, 1'b1);
		chk(high_w, 16'd3);
		// A reset in mid-run must restore the reset values
		do_reset;
		rd(a_m2, 8'h00);
		rd(a_m1, 8'h00);
		rd(a_ctl, 8'h00);
		conclude;
	end
endmodule // test_tcg_timer
